// >>> logic/scs_defs.svh
// Constants for the system clock source select block.
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

// =====================================================================
// Register map (byte addresses) and decode width
// =====================================================================
`define SCS_ADDR_W          8
`define SCS_ADDR_CTRL       8'h00
`define SCS_ADDR_TRIM       8'h04
`define SCS_ADDR_IRQ_STAT   8'h08
`define SCS_ADDR_IRQ_MASK   8'h0c

// =====================================================================
// Field layout
// =====================================================================
`define SCS_FSEL_HI         5
`define SCS_FSEL_LO         4
`define SCS_HTS_BIT         2
`define SCS_LTS_BIT         1
`define SCS_TRIM_W          5
`define SCS_IRQ_W           3
`define SCS_IRQ_HF_STABLE   0
`define SCS_IRQ_LF_STABLE   1
`define SCS_IRQ_START_DONE  2

// =====================================================================
// Frequency select codes, reset values and bus response codes
// =====================================================================
`define SCS_FSEL_8M         2'h3
`define SCS_FSEL_4M         2'h2
`define SCS_FSEL_1M         2'h1
`define SCS_FSEL_31K        2'h0
`define SCS_FSEL_RST        2'h1
`define SCS_TRIM_RST        5'h00
`define SCS_RESP_OKAY       2'h0
`define SCS_RESP_SLVERR     2'h2

// =====================================================================
// Timing
// =====================================================================
`define SCS_CLK_HZ          25000000
`define SCS_CLK_MHZ         25
`define SCS_BIAS_NS         10000
`define SCS_BIAS_CYC        ((`SCS_BIAS_NS * `SCS_CLK_MHZ + 999) / 1000)
`define SCS_HF_START_US     5
`define SCS_LF_START_US     2000
`define SCS_CNT_W           20

// =====================================================================
// Oscillator models: phase accumulators on aclk
// =====================================================================
`define SCS_NCO_W           24
`define SCS_HF_HZ           64'd8000000
`define SCS_LF_HZ           64'd31000
`define SCS_HF_INC          ((`SCS_HF_HZ << 24) / 64'd25000000)
`define SCS_LF_INC          ((`SCS_LF_HZ << 24) / 64'd25000000)
`define SCS_TRIM_SHIFT      7

`endif

// >>> logic/scs_pkg.sv
// Types shared by the system clock source select block.
package scs_pkg;

  typedef enum logic [1:0] {
    SCS_ST_HOLD,
    SCS_ST_RUN,
    SCS_ST_SLEEP
  } scs_state_e;

  typedef logic [1:0] scs_fsel_t;

endpackage : scs_pkg

// >>> logic/scs_osc_tick.sv
// Phase accumulator that models one internal oscillator as tick pulses.
`timescale 1ns/1ps
`default_nettype none
`include "scs_defs.svh"

module scs_osc_tick
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  run,
  input  wire logic [`SCS_NCO_W-1:0] inc,
  output logic                       tick
);

  logic [`SCS_NCO_W:0] sum;
  logic [`SCS_NCO_W-1:0] acc_q;

  assign sum = {1'b0, acc_q} + {1'b0, inc};

  // The carry out of the accumulator marks one oscillator period.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc_q <= '0;
      tick  <= 1'b0;
    end
    else if (run)
    begin
      acc_q <= sum[`SCS_NCO_W-1:0];
      tick  <= sum[`SCS_NCO_W];
    end
    else
    begin
      tick  <= 1'b0;
    end
  end

endmodule : scs_osc_tick
`default_nettype wire

// >>> logic/scs_clock_select.sv
// System clock source select, start-up delay and clock output.
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "scs_defs.svh"

module scs_clock_select
#(
  parameter int unsigned HF_START_CYC = `SCS_HF_START_US * `SCS_CLK_MHZ,
  parameter int unsigned LF_START_CYC = `SCS_LF_START_US * `SCS_CLK_MHZ
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        clock_source_select_bit,
  input  wire logic        clock_out_disable,
  input  wire logic        ext_clock_in_pin,
  input  wire logic        sleep_req,
  input  wire logic        wake_req,
  input  wire logic        periph_keep_osc,
  input  wire logic        gpio_out_val,
  input  wire logic        gpio_oe_val,
  input  wire logic        clock_out_pin_i,
  output logic             clock_out_pin_o,
  output logic             clock_out_pin_oe,
  output logic             port_read_bit,
  output logic             sys_clk_en,
  output logic             run_ready,
  output logic             irq
);

  // ===================================================================
  // Register state
  // ===================================================================
  scs_pkg::scs_fsel_t        fsel_q;
  scs_pkg::scs_fsel_t        act_sel_q;
  logic [`SCS_TRIM_W-1:0]    trim_q;
  logic [`SCS_TRIM_W-1:0]    trim_act_q;
  logic [`SCS_IRQ_W-1:0]     stat_q;
  logic [`SCS_IRQ_W-1:0]     mask_q;
  logic [`SCS_IRQ_W-1:0]     event_set;
  scs_pkg::scs_state_e       state_q;
  logic                      aw_got_q;
  logic                      w_got_q;
  logic [`SCS_ADDR_W-1:0]    aw_addr_q;
  logic [31:0]               w_data_q;
  logic                      w_strb0_q;
  logic                      wr_fire;
  logic                      wr_hit;
  logic [31:0]               rd_word;
  logic                      rd_hit;

  // ===================================================================
  // AXI4-Lite write channel
  // ===================================================================
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  assign wr_hit  = (aw_addr_q == `SCS_ADDR_CTRL) ||
                   (aw_addr_q == `SCS_ADDR_TRIM) ||
                   (aw_addr_q == `SCS_ADDR_IRQ_STAT) ||
                   (aw_addr_q == `SCS_ADDR_IRQ_MASK);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= '0;
      w_strb0_q     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SCS_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_got_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= s_axi_awaddr[`SCS_ADDR_W-1:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q   <= 1'b1;
        w_data_q  <= s_axi_wdata;
        w_strb0_q <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `SCS_RESP_OKAY : `SCS_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        aw_got_q      <= 1'b0;
        w_got_q       <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Control and trim registers; only byte lane 0 holds bits.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fsel_q <= `SCS_FSEL_RST;
      trim_q <= `SCS_TRIM_RST;
      mask_q <= '0;
    end
    else if (wr_fire && w_strb0_q)
    begin
      if (aw_addr_q == `SCS_ADDR_CTRL)
        fsel_q <= w_data_q[`SCS_FSEL_HI:`SCS_FSEL_LO];
      if (aw_addr_q == `SCS_ADDR_TRIM)
        trim_q <= w_data_q[`SCS_TRIM_W-1:0];
      if (aw_addr_q == `SCS_ADDR_IRQ_MASK)
        mask_q <= w_data_q[`SCS_IRQ_W-1:0];
    end
  end

  // ===================================================================
  // Oscillators, stable flags and frequency postscaler
  // ===================================================================
  logic                    osc_allowed;
  logic                    hf_run;
  logic                    lf_run;
  logic                    hf_tick;
  logic                    lf_tick;
  logic [`SCS_CNT_W-1:0]   hf_cnt_q;
  logic [`SCS_CNT_W-1:0]   lf_cnt_q;
  logic                    hts_q;
  logic                    lts_q;
  logic [2:0]              post_q;
  logic signed [`SCS_NCO_W+1:0] hf_inc_full;
  logic [`SCS_NCO_W-1:0]   hf_inc;
  logic [`SCS_NCO_W-1:0]   hf_base;
  logic [`SCS_NCO_W-1:0]   lf_inc;

  assign osc_allowed = (state_q != scs_pkg::SCS_ST_SLEEP) || periph_keep_osc;
  assign hf_run = osc_allowed && !clock_source_select_bit &&
                  (fsel_q != `SCS_FSEL_31K || act_sel_q != `SCS_FSEL_31K);
  assign lf_run = osc_allowed && !clock_source_select_bit &&
                  (fsel_q == `SCS_FSEL_31K || act_sel_q == `SCS_FSEL_31K);
  assign hf_base = `SCS_NCO_W'(`SCS_HF_INC);
  assign lf_inc  = `SCS_NCO_W'(`SCS_LF_INC);
  // Signed trim scales a fixed fraction of the base rate per step.
  assign hf_inc_full = $signed({2'b00, hf_base}) +
                       ($signed(trim_act_q) *
                        $signed({2'b00, hf_base >> `SCS_TRIM_SHIFT}));
  assign hf_inc = hf_inc_full[`SCS_NCO_W-1:0];

  scs_osc_tick u_hf_osc
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (hf_run),
    .inc     (hf_inc),
    .tick    (hf_tick)
  );

  scs_osc_tick u_lf_osc
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (lf_run),
    .inc     (lf_inc),
    .tick    (lf_tick)
  );

  // New trim takes effect at the next oscillator period.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      trim_act_q <= `SCS_TRIM_RST;
    else if (hf_tick || !hf_run)
      trim_act_q <= trim_q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hf_cnt_q <= '0;
      hts_q    <= 1'b0;
    end
    else if (!hf_run)
    begin
      hf_cnt_q <= '0;
      hts_q    <= 1'b0;
    end
    else if (hf_cnt_q == `SCS_CNT_W'(HF_START_CYC))
      hts_q    <= 1'b1;
    else
      hf_cnt_q <= hf_cnt_q + 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lf_cnt_q <= '0;
      lts_q    <= 1'b0;
    end
    else if (!lf_run)
    begin
      lf_cnt_q <= '0;
      lts_q    <= 1'b0;
    end
    else if (lf_cnt_q == `SCS_CNT_W'(LF_START_CYC))
      lts_q    <= 1'b1;
    else
      lf_cnt_q <= lf_cnt_q + 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      post_q <= '0;
    else if (hf_tick)
      post_q <= post_q + 1'b1;
  end

  // ===================================================================
  // Clock selection and glitch-free switch
  // ===================================================================
  logic [2:0] ext_sync_q;
  logic       ext_lvl_q;
  logic       ext_tick;
  logic       int_tick;
  logic       sel_tick;
  logic [1:0] div4_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_sync_q <= '0;
      ext_lvl_q  <= 1'b0;
    end
    else
    begin
      ext_sync_q <= {ext_sync_q[1:0], ext_clock_in_pin};
      if (ext_sync_q[1] == ext_sync_q[2])
        ext_lvl_q <= ext_sync_q[2];
    end
  end

  assign ext_tick = (ext_sync_q[1] == ext_sync_q[2]) && ext_sync_q[2] &&
                    !ext_lvl_q;

  always_comb
  begin
    unique case (act_sel_q)
      `SCS_FSEL_8M:  int_tick = hf_tick;
      `SCS_FSEL_4M:  int_tick = hf_tick && post_q[0];
      `SCS_FSEL_1M:  int_tick = hf_tick && (post_q == 3'h7);
      `SCS_FSEL_31K: int_tick = lf_tick;
    endcase
  end

  // A stopped external clock simply yields no ticks; nothing is lost.
  assign sel_tick = clock_source_select_bit ? ext_tick : int_tick;

  // The selection changes only where a divided period ends.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      act_sel_q <= `SCS_FSEL_RST;
    else if (act_sel_q != fsel_q && int_tick && div4_q == 2'h3)
      act_sel_q <= fsel_q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div4_q <= '0;
    else if (sel_tick)
      div4_q <= div4_q + 1'b1;
  end

  // ===================================================================
  // Start-up delay and sleep
  // ===================================================================
  logic [`SCS_CNT_W-1:0] bias_cnt_q;
  logic                  bias_done;
  logic                  osc_ready;

  assign bias_done = bias_cnt_q == `SCS_CNT_W'(`SCS_BIAS_CYC);
  assign osc_ready = clock_source_select_bit ||
                     ((act_sel_q == `SCS_FSEL_31K) ? lts_q : hts_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bias_cnt_q <= '0;
    else if (state_q != scs_pkg::SCS_ST_HOLD)
      bias_cnt_q <= '0;
    else if (!bias_done)
      bias_cnt_q <= bias_cnt_q + 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_q <= scs_pkg::SCS_ST_HOLD;
    else
    begin
      unique case (state_q)
        scs_pkg::SCS_ST_HOLD:
          if (bias_done && osc_ready)
            state_q <= scs_pkg::SCS_ST_RUN;
        scs_pkg::SCS_ST_RUN:
          if (sleep_req)
            state_q <= scs_pkg::SCS_ST_SLEEP;
        scs_pkg::SCS_ST_SLEEP:
          if (wake_req)
            state_q <= scs_pkg::SCS_ST_HOLD;
        default:
          state_q <= scs_pkg::SCS_ST_HOLD;
      endcase
    end
  end

  // ===================================================================
  // Outputs: clock enable, clock output pin, port read
  // ===================================================================
  logic [2:0] pin_sync_q;
  logic       pin_lvl_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_sync_q <= '0;
      pin_lvl_q  <= 1'b0;
    end
    else
    begin
      pin_sync_q <= {pin_sync_q[1:0], clock_out_pin_i};
      if (pin_sync_q[1] == pin_sync_q[2])
        pin_lvl_q <= pin_sync_q[2];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sys_clk_en       <= 1'b0;
      run_ready        <= 1'b0;
      clock_out_pin_o  <= 1'b0;
      clock_out_pin_oe <= 1'b0;
      port_read_bit    <= 1'b0;
    end
    else
    begin
      sys_clk_en <= sel_tick && (state_q == scs_pkg::SCS_ST_RUN);
      run_ready  <= state_q == scs_pkg::SCS_ST_RUN;
      if (!clock_out_disable)
      begin
        clock_out_pin_o  <= div4_q[1];
        clock_out_pin_oe <= 1'b1;
        port_read_bit    <= 1'b0;
      end
      else
      begin
        clock_out_pin_o  <= gpio_out_val;
        clock_out_pin_oe <= gpio_oe_val;
        port_read_bit    <= pin_lvl_q;
      end
    end
  end

  // ===================================================================
  // Interrupt status, mask and read path
  // ===================================================================
  logic hts_d1_q;
  logic lts_d1_q;
  logic run_d1_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hts_d1_q <= 1'b0;
      lts_d1_q <= 1'b0;
      run_d1_q <= 1'b0;
    end
    else
    begin
      hts_d1_q <= hts_q;
      lts_d1_q <= lts_q;
      run_d1_q <= state_q == scs_pkg::SCS_ST_RUN;
    end
  end

  always_comb
  begin
    event_set = '0;
    event_set[`SCS_IRQ_HF_STABLE]  = hts_q && !hts_d1_q;
    event_set[`SCS_IRQ_LF_STABLE]  = lts_q && !lts_d1_q;
    event_set[`SCS_IRQ_START_DONE] = (state_q == scs_pkg::SCS_ST_RUN) &&
                                     !run_d1_q;
  end

  // Write one clears; a same-cycle event wins over the clear.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stat_q <= '0;
    else if (wr_fire && w_strb0_q && aw_addr_q == `SCS_ADDR_IRQ_STAT)
      stat_q <= (stat_q & ~w_data_q[`SCS_IRQ_W-1:0]) | event_set;
    else
      stat_q <= stat_q | event_set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(stat_q & mask_q);
  end

  always_comb
  begin
    rd_word = '0;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr[`SCS_ADDR_W-1:0])
      `SCS_ADDR_CTRL:
      begin
        rd_word[`SCS_FSEL_HI:`SCS_FSEL_LO] = fsel_q;
        rd_word[`SCS_HTS_BIT]              = hts_q;
        rd_word[`SCS_LTS_BIT]              = lts_q;
      end
      `SCS_ADDR_TRIM:     rd_word[`SCS_TRIM_W-1:0] = trim_q;
      `SCS_ADDR_IRQ_STAT: rd_word[`SCS_IRQ_W-1:0]  = stat_q;
      `SCS_ADDR_IRQ_MASK: rd_word[`SCS_IRQ_W-1:0]  = mask_q;
      default:            rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `SCS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? `SCS_RESP_OKAY : `SCS_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

endmodule : scs_clock_select
`default_nettype wire

// >>> bench/scs_ext_clk.sv
// External clock source model that drives the clock input pin.
`timescale 1ns/1ps
`default_nettype none

module scs_ext_clk
#(
  parameter int HALF_NS = 203
)
(
  input  wire logic run,
  output logic      clk_pin
);
  // ==========
  // Clock generation
  // The half period is not a multiple of aclk so the phase drifts.
  // The half-nanosecond offset keeps pin edges off the aclk edges.
  initial
  begin
    clk_pin = 1'b0;
    #0.5;
    forever
    begin
      #(HALF_NS);
      clk_pin = run ? ~clk_pin : 1'b0;
    end
  end
endmodule : scs_ext_clk

`default_nettype wire

// >>> bench/scs_clock_select_sva.sv
// Port-level assertions for the system clock source select block.
`timescale 1ns/1ps
`default_nettype none

module scs_clock_select_sva
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clock_source_select_bit,
  input wire logic clock_out_disable,
  input wire logic ext_clock_in_pin,
  input wire logic wake_req,
  input wire logic gpio_oe_val,
  input wire logic clock_out_pin_o,
  input wire logic clock_out_pin_oe,
  input wire logic port_read_bit,
  input wire logic sys_clk_en,
  input wire logic run_ready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========
  // Helper counters
  logic [9:0] hold_q;
  logic [2:0] en_q;
  logic [1:0] arm_q;
  logic       prev_q;
  always_ff @(posedge aclk)
  begin
    prev_q <= clock_out_pin_o;
    if (!aresetn || run_ready || wake_req)
      hold_q <= 10'h0;
    else if (hold_q != 10'h3ff)
      hold_q <= hold_q + 10'h1;
  end
  // The first two toggles after enabling may span a partial period.
  // Outside run the pin follows the oscillator with no clock enable.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clock_out_disable || !run_ready)
      arm_q <= 2'h0;
    else if (clock_out_pin_o != prev_q && arm_q != 2'h2)
      arm_q <= arm_q + 2'h1;
    if (!aresetn || clock_out_pin_o != prev_q)
      en_q <= {2'h0, sys_clk_en};
    else
      en_q <= en_q + {2'h0, sys_clk_en};
  end
  // ==========
  // Properties
  a_startup_bias: assert property ($rose(run_ready) |-> hold_q >= 10'd250)
    else $error("run started before the bias delay");
  a_no_run_idle: assert property (!run_ready [*2] |-> !sys_clk_en)
    else $error("clock enable outside run");
  a_clock_out_pin_quarter: assert property (arm_q == 2'h2 &&
    clock_out_pin_o != prev_q |-> en_q == 3'h2)
    else $error("clock output is not a quarter of the clock");
  a_clock_out_pin_drive: assert property (!clock_out_disable [*3] |-> clock_out_pin_oe)
    else $error("clock output pin not driven");
  a_port_zero: assert property (!clock_out_disable [*3] |-> !port_read_bit)
    else $error("port bit not zero with clock output");
  a_gpio_release: assert property (clock_out_disable [*3] |->
    clock_out_pin_oe == $past(gpio_oe_val))
    else $error("pin enable does not follow the port");
  a_ext_halt: assert property ((clock_source_select_bit &&
    !ext_clock_in_pin) [*8] |-> !sys_clk_en)
    else $error("clock enable with stopped external clock");
  a_ext_tick: assert property (clock_source_select_bit && run_ready &&
    $rose(ext_clock_in_pin) |-> ##[1:8] sys_clk_en)
    else $error("external edge gave no clock enable");
  c_run_start: cover property ($rose(run_ready));
  c_clock_out_pin: cover property (arm_q == 2'h2 && clock_out_pin_o != prev_q);
  c_ext_tick: cover property (clock_source_select_bit && sys_clk_en);
endmodule : scs_clock_select_sva

bind scs_clock_select scs_clock_select_sva scs_clock_select_sva_inst (.*);

`default_nettype wire

// >>> bench/system_clock_source_select_tb_top.sv
// Self-checking bench for the system clock source select block.
`timescale 1ns/1ps
`default_nettype none

module system_clock_source_select_tb_top;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, sleep_req, irq;
  logic        clock_source_select_bit, clock_out_disable, wake_req;
  logic        periph_keep_osc, gpio_out_val, gpio_oe_val, clock_out_pin_o;
  logic        clock_out_pin_oe, port_read_bit, sys_clk_en, run_ready;
  logic        ext_run, ext_drv;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat, v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  wire         ext_clock_in_pin, clock_out_pin_i;
  int          cnt, checked, mismatches, seed;
  int          model[4];
  int          wmask[4] = '{32'h30, 32'h1f, 0, 32'h7};
  int          rate[4] = '{2, 80, 320, 640};
  assign clock_out_pin_i = clock_out_pin_oe ? clock_out_pin_o : ext_drv;
  scs_ext_clk scs_ext_clk_inst (.run(ext_run), .clk_pin(ext_clock_in_pin));
  scs_clock_select #(.HF_START_CYC(20), .LF_START_CYC(200))
    scs_clock_select_inst (.*);
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial
  begin
    #2400000;
    mismatches++;
    stop_test();
  end
  // ==========
  // Tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic near(input int c, input int e, input int t);
    chk(32'(c >= e - t && c <= e + t), 32'h1);
  endtask : near
  task automatic count(input int s, input int n);
    repeat (s) @(posedge aclk);
    cnt = 0;
    repeat (n) @(posedge aclk) cnt += int'(sys_clk_en);
  endtask : count
  task automatic wait_run();
    cnt = 0;
    while (run_ready !== 1'b1 && cnt < 5000) @(posedge aclk) cnt++;
  endtask : wait_run
  task automatic reset_dut();
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    model = '{32'h10, 0, 5, 0};
    wait_run();
  endtask : reset_dut
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
    if (a == 8'h08) model[2] &= ~d;
    else if (a < 8'h10 && s_axi_wstrb[0]) model[a[3:2]] = d & wmask[a[3:2]];
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= {24'h0, a};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        {rdat, resp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
      end
    end
    while (s_axi_arvalid || s_axi_rready);
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] m);
    rd(a);
    chk(rdat & m, model[a[3:2]] & m);
  endtask : rchk
  // ==========
  // Scenarios
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, sleep_req, wake_req} = '0;
    {clock_source_select_bit, clock_out_disable, periph_keep_osc} = '0;
    {gpio_out_val, gpio_oe_val, ext_run, ext_drv} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    seed = 36;
    reset_dut();
    near(cnt, 252, 4);
    rchk(8'h00, 32'hfffffff9);
    chk(rdat[2:1], 2'h2);
    rchk(8'h04, 32'hffffffff);
    rchk(8'h08, 32'h5);
    chk(irq, 1'b0);
    wr(8'h0c, 32'h4);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    s_axi_wstrb <= 4'he;
    wr(8'h0c, 32'h0);
    s_axi_wstrb <= 4'hf;
    rchk(8'h0c, 32'hffffffff);
    chk(irq, 1'b1);
    wr(8'h08, 32'h7);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    rchk(8'h08, 32'h5);
    wr(8'h10, 32'h3);
    chk(resp, 2'h2);
    rd(8'h10);
    chk({rdat[1:0], resp}, 4'h2);
    repeat (4)
    begin
      v = $random(seed);
      wr(8'h04, v);
      rchk(8'h04, 32'hffffffff);
    end
    $display("test registers done");
    wr(8'h04, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, 32'(i) << 4);
      rchk(8'h00, 32'h30);
      count(3300, 2000);
      near(cnt, rate[i], 3);
    end
    wr(8'h04, 32'hf);
    count(50, 2000);
    near(cnt, 715, 4);
    wr(8'h04, 32'h10);
    count(50, 2000);
    near(cnt, 560, 4);
    $display("test frequency done");
    v = $random(seed);
    {clock_out_disable, gpio_oe_val, gpio_out_val, ext_drv} <= {2'h3, v[1:0]};
    repeat (3) @(posedge aclk);
    chk({clock_out_pin_oe, clock_out_pin_o}, {1'b1, v[1]});
    gpio_oe_val <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(port_read_bit, v[0]);
    {clock_out_disable, ext_drv} <= 2'h1;
    repeat (6) @(posedge aclk);
    chk({clock_out_pin_oe, port_read_bit}, 2'h2);
    $display("test pins done");
    for (int k = 0; k < 2; k++)
    begin
      {periph_keep_osc, sleep_req} <= {k == 0, 1'b1};
      @(posedge aclk);
      sleep_req <= 1'b0;
      count(5, 200);
      chk({run_ready, 31'(cnt)}, 32'h0);
      wake_req <= 1'b1;
      @(posedge aclk);
      wake_req <= 1'b0;
      wait_run();
      near(cnt, 252, 4);
    end
    $display("test sleep done");
    {clock_source_select_bit, clock_out_disable, ext_run} <= 3'h7;
    reset_dut();
    near(cnt, 252, 4);
    count(20, 2030);
    near(cnt, 200, 3);
    wr(8'h04, 32'h9);
    ext_run <= 1'b0;
    count(100, 400);
    chk(cnt, 32'h0);
    ext_run <= 1'b1;
    count(20, 2030);
    near(cnt, 200, 3);
    rchk(8'h04, 32'hffffffff);
    $display("test external done");
    stop_test();
  end
endmodule : system_clock_source_select_tb_top

`default_nettype wire
